// ==== mpc_capture.sv ====
// Multiplexed pixel port capture: latches eight samples per channel and the
// video controls on each load rising edge, then presents them one per pixel.
// Assumes a single 125 MHz clock; all port inputs are asynchronous to it.
//
// Overview of operation
// R1: Capture eight 8-bit samples per channel each load
// R2: Blank low forces blanking level, ignores pixels
// R3: Pedestal chosen by pedestal enable bit
// R4: Blank is captured on the load edge
// R5: Line and frame pulses captured on load
// R6: Field input zero even, one odd
// R7: Controller changes field only in vertical blank
// R8: Pixel rate is eight times load rate
// R9: Load output is pixel rate over eight
// R10: Composite sync decoded only when enabled
// R11: Samples presented A to H, one per pixel
`timescale 1ns/1ps
`include "mpc_map.svh"
module mpc_capture
  import mpc_pkg::*;
#(
  parameter int PER_BITS = `MPC_PER_BITS
) (
  input  wire logic     clk_sys_i,
  input  wire logic     rst_i,
  input  wire logic     pixel_load_in_i,
  input  wire mpc_pix_s pixel_samples_i,
  input  wire mpc_ctl_s video_ctl_i,
  input  wire logic     pedestal_enable_bit_i,
  input  wire logic     sync_decode_en_i,
  output logic          pixel_load_out_o,
  output logic          pixel_stb_o,
  output mpc_dac_s      dac_word_o,
  output logic          field_odd_o
);

  // --------------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------------
  logic     load_f;
  mpc_pix_s pix_f;
  mpc_ctl_s ctl_f;
  logic     ped_f;
  logic     sen_f;

  mpc_sync #(.W(1)) u_sync_load (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .d_i       (pixel_load_in_i),
    .q_o       (load_f)
  );

  mpc_sync #(.W($bits(mpc_pix_s))) u_sync_pix (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .d_i       (pixel_samples_i),
    .q_o       (pix_f)
  );

  mpc_sync #(.W($bits(mpc_ctl_s))) u_sync_ctl (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .d_i       (video_ctl_i),
    .q_o       (ctl_f)
  );

  mpc_sync #(.W(2)) u_sync_cfg (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .d_i       ({pedestal_enable_bit_i, sync_decode_en_i}),
    .q_o       ({ped_f, sen_f})
  );

  // --------------------------------------------------------------------
  // Load edge, period measurement and pixel step
  // --------------------------------------------------------------------
  logic                          load_q_r;
  logic                          load_rise;
  logic [PER_BITS-1:0]           per_cnt_r;
  logic [PER_BITS-1:0]           period_r;
  logic [PER_BITS-1:0]           step_raw;
  logic [PER_BITS-1:0]           step_len;
  logic [PER_BITS-1:0]           step_cnt_r;
  logic                          pix_stb;

  assign load_rise = load_f & ~load_q_r;
  // The pixel clock is recovered from the measured load period; any
  // remainder of the division is absorbed by the wait for the next load.
  assign step_raw  = period_r >> `MPC_STEP_SHIFT; // R8
  assign step_len  = (step_raw == '0) ? `MPC_STEP_MIN : step_raw;
  assign pix_stb   = (step_cnt_r == step_len - `MPC_STEP_MIN); // R8

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      load_q_r   <= 1'b0;
      per_cnt_r  <= '0;
      period_r   <= '0;
      step_cnt_r <= '0;
    end else begin
      load_q_r <= load_f;
      if (load_rise) begin
        per_cnt_r  <= '0;
        period_r   <= per_cnt_r + `MPC_STEP_MIN;
        step_cnt_r <= '0;
      end else begin
        if (per_cnt_r != '1) begin
          per_cnt_r <= per_cnt_r + `MPC_STEP_MIN;
        end
        step_cnt_r <= pix_stb ? '0 : step_cnt_r + `MPC_STEP_MIN;
      end
    end
  end

  // --------------------------------------------------------------------
  // Capture on load
  // --------------------------------------------------------------------
  mpc_pix_s cap_pix_r;
  mpc_ctl_s cap_ctl_r;
  logic     pending_r;
  logic     take_set;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cap_pix_r <= '0;
      cap_ctl_r <= '0;
      pending_r <= 1'b0;
    end else begin
      if (load_rise) begin
        cap_pix_r <= pix_f; // R1
        cap_ctl_r <= ctl_f; // R4 R5
      end
      if (load_rise) begin
        pending_r <= 1'b1;
      end else if (take_set) begin
        pending_r <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------
  // Presentation sequencer
  // --------------------------------------------------------------------
  mpc_state_e                 state_r;
  mpc_state_e                 state_nxt;
  logic [`MPC_IDX_BITS-1:0]   idx_r;
  logic                       last_pix;
  mpc_pix_s                   cur_pix_r;
  mpc_ctl_s                   cur_ctl_r;
  mpc_dac_s                   dac_nxt;
  logic                       lo_nxt;

  assign last_pix = (state_r == MPC_SHIFT) && pix_stb && (idx_r == `MPC_LAST_IDX);
  // A captured set waits in the pending register until the previous set has
  // run out, so samples are never dropped mid-sequence.
  assign take_set = pending_r && (state_r != MPC_SHIFT || last_pix); // R11

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      MPC_IDLE: begin
        if (take_set) begin
          state_nxt = MPC_SHIFT;
        end
      end
      MPC_SHIFT: begin
        if (take_set) begin
          state_nxt = MPC_SHIFT;
        end else if (last_pix) begin
          state_nxt = MPC_HOLD;
        end
      end
      MPC_HOLD: begin
        if (take_set) begin
          state_nxt = MPC_SHIFT;
        end
      end
      default: state_nxt = MPC_IDLE;
    endcase
  end

  // Blanking overrides the samples; sync passes only when decoding is on.
  assign dac_nxt.red         = cur_ctl_r.blank_n ? cur_pix_r.red_sample_inputs[idx_r]
                                                 : `MPC_BLANK_CODE; // R2
  assign dac_nxt.green       = cur_ctl_r.blank_n ? cur_pix_r.green_sample_inputs[idx_r]
                                                 : `MPC_BLANK_CODE; // R2
  assign dac_nxt.blue        = cur_ctl_r.blank_n ? cur_pix_r.blue_sample_inputs[idx_r]
                                                 : `MPC_BLANK_CODE; // R2
  assign dac_nxt.blank       = ~cur_ctl_r.blank_n; // R2
  assign dac_nxt.sync        = cur_ctl_r.composite_timing_pulse & sen_f; // R10
  assign dac_nxt.pedestal    = ped_f; // R3
  assign dac_nxt.line_pulse  = cur_ctl_r.line_pulse; // R5
  assign dac_nxt.frame_pulse = cur_ctl_r.frame_pulse; // R5
  assign lo_nxt              = (idx_r < `MPC_HALF_IDX); // R9

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_r          <= MPC_IDLE;
      idx_r            <= '0;
      cur_pix_r        <= '0;
      cur_ctl_r        <= '0;
      dac_word_o       <= '0;
      pixel_load_out_o <= 1'b0;
      pixel_stb_o      <= 1'b0;
      field_odd_o      <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      pixel_stb_o <= 1'b0;
      if (state_r == MPC_SHIFT && pix_stb) begin
        dac_word_o       <= dac_nxt;
        pixel_stb_o      <= 1'b1;
        pixel_load_out_o <= lo_nxt; // R9
        if (idx_r != `MPC_LAST_IDX) begin
          idx_r <= idx_r + 3'h1; // R11
        end
      end
      // A take may share a cycle with the last pixel; it wins index and load.
      if (take_set) begin
        cur_pix_r        <= cap_pix_r;
        cur_ctl_r        <= cap_ctl_r;
        idx_r            <= '0;
        pixel_load_out_o <= 1'b1; // R9
        field_odd_o      <= cap_ctl_r.field_odd; // R6
      end
    end
  end

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  property p_capture_pix;
    @(posedge clk_sys_i) disable iff (rst_i)
      load_rise |=> cap_pix_r == $past(pix_f);
  endproperty
  a_capture_pix: assert property (p_capture_pix) else $error("pixel set not captured"); // R1

  property p_blank_out;
    @(posedge clk_sys_i) disable iff (rst_i)
      (state_r == MPC_SHIFT && pix_stb && !take_set && !cur_ctl_r.blank_n)
      |=> dac_word_o.blank && dac_word_o.red == `MPC_BLANK_CODE
          && dac_word_o.blue == `MPC_BLANK_CODE && dac_word_o.green == `MPC_BLANK_CODE;
  endproperty
  a_blank_out: assert property (p_blank_out) else $error("blank did not force level"); // R2

  property p_pedestal;
    @(posedge clk_sys_i) disable iff (rst_i)
      pixel_stb_o |-> dac_word_o.pedestal == $past(ped_f);
  endproperty
  a_pedestal: assert property (p_pedestal) else $error("pedestal not from enable bit"); // R3

  property p_blank_cap;
    @(posedge clk_sys_i) disable iff (rst_i)
      load_rise ##1 !load_rise [*2] |-> cap_ctl_r.blank_n == $past(ctl_f.blank_n, 2);
  endproperty
  a_blank_cap: assert property (p_blank_cap) else $error("blank not held from load"); // R4

  property p_sync_cap;
    @(posedge clk_sys_i) disable iff (rst_i)
      load_rise |=> cap_ctl_r.line_pulse == $past(ctl_f.line_pulse)
                    && cap_ctl_r.frame_pulse == $past(ctl_f.frame_pulse);
  endproperty
  a_sync_cap: assert property (p_sync_cap) else $error("line or frame pulse missed"); // R5

  property p_field;
    @(posedge clk_sys_i) disable iff (rst_i)
      take_set |=> field_odd_o == $past(cap_ctl_r.field_odd);
  endproperty
  a_field: assert property (p_field) else $error("field parity wrong"); // R6

  property p_step;
    @(posedge clk_sys_i) disable iff (rst_i)
      step_cnt_r < step_len;
  endproperty
  a_step: assert property (p_step) else $error("pixel step overran"); // R8

  property p_load_out;
    @(posedge clk_sys_i) disable iff (rst_i)
      take_set |=> pixel_load_out_o && idx_r == '0;
  endproperty
  a_load_out: assert property (p_load_out) else $error("load out not in phase"); // R9

  property p_sync_gate;
    @(posedge clk_sys_i) disable iff (rst_i)
      pixel_stb_o && !$past(sen_f) |-> !dac_word_o.sync;
  endproperty
  a_sync_gate: assert property (p_sync_gate) else $error("sync passed while disabled"); // R10

  property p_order;
    @(posedge clk_sys_i) disable iff (rst_i)
      (state_r == MPC_SHIFT && pix_stb && !take_set && idx_r != `MPC_LAST_IDX)
      |=> idx_r == $past(idx_r) + 3'h1;
  endproperty
  a_order: assert property (p_order) else $error("sample order broken"); // R11

endmodule

// ==== mpc_ctrl_model.sv ====
// Behavioural graphics controller feeding the multiplexed pixel port.
// Assumes the bench calls send_set once per set; load stands low between sets.
`timescale 1ns/1ps
module mpc_ctrl_model
  import mpc_pkg::*;
(
  input  wire logic clk_sys_i,
  output logic      load_o,
  output mpc_pix_s  pix_o,
  output mpc_ctl_s  ctl_o
);
  logic fld = 1'b0;

  initial begin
    load_o = 1'b0;
    pix_o  = '0;
    ctl_o  = 5'h10;
  end

  // -----------------------------------------------------------------------
  // One set per call
  // -----------------------------------------------------------------------
  // Lines are inverted once the hold time has run out, so a late sample shows.
  // Field parity is kept out of the inversion, since it may only move in blanking.
  task automatic send_set(input mpc_pix_s p, input mpc_ctl_s c);
    mpc_ctl_s o;
    @(posedge clk_sys_i);
    #1;
    if (!c.blank_n) fld = c.field_odd;
    o = c;
    o.composite_timing_pulse = c.composite_timing_pulse & ~c.blank_n;
    o.field_odd = fld;
    pix_o = p;
    ctl_o = o;
    #62.5 load_o = 1'b1;
    #62.5 load_o = 1'b0;
    o = ~o;
    o.field_odd = fld;
    pix_o = ~pix_o;
    ctl_o = o;
  endtask
endmodule

// ==== mpc_map.svh ====
// Constant map for the multiplexed pixel port capture block.
// Assumes inclusion by the package and the design files by bare name.
`ifndef MPC_MAP_SVH
`define MPC_MAP_SVH

// ----------------------------------------------------------------------
// Port geometry
// ----------------------------------------------------------------------
`define MPC_SAMPLES      8
`define MPC_SAMPLE_BITS  8
`define MPC_IDX_BITS     3
`define MPC_LAST_IDX     3'h7
`define MPC_HALF_IDX     3'h4

// ----------------------------------------------------------------------
// Levels, widths and timing
// ----------------------------------------------------------------------
`define MPC_BLANK_CODE   8'h00
`define MPC_SYNC_STAGES  3
`define MPC_PER_BITS     12
`define MPC_STEP_SHIFT   3
`define MPC_STEP_MIN     12'h001

`endif

// ==== mpc_pkg.sv ====
// Types shared by the multiplexed pixel port capture block.
// Assumes mpc_map.svh is on the include path.
package mpc_pkg;
  `include "mpc_map.svh"

  typedef logic [`MPC_SAMPLE_BITS-1:0] mpc_code_t;

  typedef struct packed {
    logic [`MPC_SAMPLES-1:0][`MPC_SAMPLE_BITS-1:0] red_sample_inputs;
    logic [`MPC_SAMPLES-1:0][`MPC_SAMPLE_BITS-1:0] green_sample_inputs;
    logic [`MPC_SAMPLES-1:0][`MPC_SAMPLE_BITS-1:0] blue_sample_inputs;
  } mpc_pix_s;

  typedef struct packed {
    logic blank_n;
    logic line_pulse;
    logic frame_pulse;
    logic composite_timing_pulse;
    logic field_odd;
  } mpc_ctl_s;

  typedef struct packed {
    mpc_code_t red;
    mpc_code_t green;
    mpc_code_t blue;
    logic      blank;
    logic      sync;
    logic      pedestal;
    logic      line_pulse;
    logic      frame_pulse;
  } mpc_dac_s;

  typedef enum logic [1:0] {
    MPC_IDLE  = 2'b00,
    MPC_SHIFT = 2'b01,
    MPC_HOLD  = 2'b11
  } mpc_state_e;
endpackage

// ==== mpc_sync.sv ====
// Three-stage synchroniser with an agreement filter.
// Assumes its inputs come from outside the clk_sys_i domain.
`timescale 1ns/1ps
module mpc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] q_nxt;

  // The first stage feeds only the second; the output follows a bit once
  // the second and third stages agree on it.
  assign q_nxt = (s2_r & s3_r) | (q_o & (s2_r | s3_r));

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      q_o  <= '0;
    end else begin
      s1_r <= d_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_o  <= q_nxt;
    end
  end
endmodule

// ==== test_mpc_capture.sv ====
// Self-checking bench for the multiplexed pixel port capture block.
// Assumes mpc_ctrl_model plays the controller that drives the load side.
`timescale 1ns/1ps
`include "mpc_map.svh"
module test_mpc_capture;
  import mpc_pkg::*;

  // -----------------------------------------------------------------------
  // Signals and instances
  // -----------------------------------------------------------------------
  logic     clk_sys_i   = 1'b0;
  logic     rst_i       = 1'b1;
  logic     ped         = 1'b0;
  logic     sen         = 1'b0;
  logic     load;
  mpc_pix_s pix;
  mpc_ctl_s ctl;
  logic     load_out;
  logic     stb;
  mpc_dac_s dac;
  logic     field;
  int       num_errors  = 0;
  int       checks_done = 0;

  always #4 clk_sys_i = ~clk_sys_i;

  mpc_ctrl_model mpc_ctrl_model_i (
    .clk_sys_i(clk_sys_i),
    .load_o   (load),
    .pix_o    (pix),
    .ctl_o    (ctl)
  );

  mpc_capture mpc_capture_i (
    .clk_sys_i            (clk_sys_i),
    .rst_i                (rst_i),
    .pixel_load_in_i      (load),
    .pixel_samples_i      (pix),
    .video_ctl_i          (ctl),
    .pedestal_enable_bit_i(ped),
    .sync_decode_en_i     (sen),
    .pixel_load_out_o     (load_out),
    .pixel_stb_o          (stb),
    .dac_word_o           (dac),
    .field_odd_o          (field)
  );

  // -----------------------------------------------------------------------
  // Shared tasks
  // -----------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    if (num_errors == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  function automatic mpc_pix_s mk(input logic [7:0] base);
    mpc_pix_s p;
    for (int i = 0; i < 8; i++) begin
      p.red_sample_inputs[i]   = base + 8'(i);
      p.green_sample_inputs[i] = base + 8'h20 + 8'(i);
      p.blue_sample_inputs[i]  = base + 8'h40 + 8'(i);
    end
    return p;
  endfunction

  // Sends one set and judges all eight pixels it yields.
  task automatic run_set(input mpc_pix_s p, input mpc_ctl_s c, input logic pe, input logic se);
    int n;
    @(posedge clk_sys_i);
    #1;
    ped = pe;
    sen = se;
    fork
      mpc_ctrl_model_i.send_set(p, c);
      for (int i = 0; i < 8; i++) begin
        n = 0;
        do begin
          @(posedge clk_sys_i);
          #1;
          n++;
        end while (stb !== 1'b1 && n < 200);
        check(stb, 1'b1);
        check({dac.red, dac.green, dac.blue}, !c.blank_n ? {3{`MPC_BLANK_CODE}} :
          {p.red_sample_inputs[i], p.green_sample_inputs[i], p.blue_sample_inputs[i]});
        check({dac.blank, dac.pedestal}, {~c.blank_n, pe});
        check({dac.line_pulse, dac.frame_pulse}, {c.line_pulse, c.frame_pulse});
        check(dac.sync, c.composite_timing_pulse & se);
        if (i == 0) check(load_out, 1'b1);
        if (i == 3) check(load_out, 1'b1);
        if (i == 4) check(load_out, 1'b0);
        if (i == 7) check(load_out, 1'b0);
      end
    join
    check(field, c.field_odd);
  endtask

  // -----------------------------------------------------------------------
  // Scenarios
  // -----------------------------------------------------------------------
  task automatic t_pixels();
    run_set(mk(8'h00), 5'h10, 1'b0, 1'b1);
    run_set(mk(8'hB8), 5'h10, 1'b1, 1'b0);
  endtask

  // Blanked sets carry busy pixel data that must not leak through.
  task automatic t_blank();
    run_set(mk(8'h33), 5'h03, 1'b0, 1'b0);
    run_set(mk(8'hC1), 5'h0F, 1'b1, 1'b1);
    run_set(mk(8'h7E), 5'h0A, 1'b0, 1'b1);
  endtask

  // Active sets with timing pulses, then a reset in mid-run.
  task automatic t_field();
    run_set(mk(8'h61), 5'h18, 1'b1, 1'b1);
    run_set(mk(8'h92), 5'h14, 1'b0, 1'b0);
    @(posedge clk_sys_i);
    #1;
    rst_i = 1'b1;
    repeat (4) @(posedge clk_sys_i);
    #1;
    rst_i = 1'b0;
    check({stb, load_out, field, dac}, 32'h0000_0000);
    run_set(mk(8'h5A), 5'h10, 1'b0, 1'b0);
  endtask

  initial begin
    repeat (8) @(posedge clk_sys_i);
    #1;
    rst_i = 1'b0;
    t_pixels();
    t_blank();
    t_field();
    stop_test();
  end

  // Eight sets take a few microseconds; this allows a wide margin.
  initial begin
    #100000;
    num_errors++;
    stop_test();
  end
endmodule
